// ---- pkg/prs_cfg.svh ----
// Purpose: timing counts and constants for the power-up ramp sequencer
// Assumes: one 100 MHz clock, counts in clock cycles except reset hold in ms and init release width in frame periods
// Notes: long counts are also module parameters so a bench can shorten them
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH
// Clock rate in kHz
`define PRS_CLK_KHZ 100000
// Reference divide in the nominal state
`define PRS_NOMINAL_DIV 16
// Reference divide in the half-rate state
`define PRS_HALF_DIV 2
// Reference divide in the full-rate state
`define PRS_FULL_DIV 1
// Half-rate lock interval in core cycles
`define PRS_HALF_CYCLES 4108
// Full-rate lock interval in core cycles
`define PRS_FULL_CYCLES 8205
// Self-test length in cycles
`define PRS_SELFTEST_CYCLES 700000
// Result pin low window after self-test
`define PRS_RESULT_LOW_CYCLES 16
// Quiet time after internal reset release
`define PRS_QUIET_CYCLES 264
// First fetch address
`define PRS_FETCH_ADDR 16'h0780
// Boot rom load length in cycles
`define PRS_ROM_CYCLES 1024
// Cycle at which the cache box configuration is loaded during rom load
`define PRS_CFG_LOADED_CYCLES 64
// Reset hold after power good, in ms, and as cycles
`define PRS_RESET_HOLD_MS 100
`define PRS_RESET_HOLD_CYCLES (`PRS_RESET_HOLD_MS * `PRS_CLK_KHZ)
// Framing clock divide from the core clock
`define PRS_FRAME_DIV 8
// Pulse width of forward clock init release, in frame periods
`define PRS_INIT_LOW_FRAMES 2
`endif

// ---- pkg/prs_pkg.sv ----
// Purpose: shared types of the power-up ramp sequencer
// Assumes: nothing beyond the config header
// Notes: types only; numbers live in the header
`default_nettype none
package prs_pkg;
	// Device reset state machine
	typedef enum logic [3:0] {
		state_init,
		state_wait_nominal,
		state_half_rate,
		state_full_rate,
		state_wait_release1,
		state_self_test,
		state_result_low,
		state_rom_load,
		state_wait_link_init,
		state_quiet,
		state_run,
		state_failed
	} prs_state_type;
	// Board controller sequence
	typedef enum logic [2:0] {
		host_power_off,
		host_reset_hold,
		host_wait_lock,
		host_release1,
		host_wait_config,
		host_release2,
		host_done
	} prs_host_type;
endpackage : prs_pkg
`default_nettype wire

// ---- pkg/prs_link_if.sv ----
// Purpose: pins between the device sequencer and the board controller
// Assumes: all pins synchronous to ref_clk
// Notes: framing clock is a one-cycle enable pulse, not a clock
`default_nettype none
interface prs_link_if;
	logic power_good_in; // Supply good, from board
	logic reset_n; // System reset, active low
	logic fwd_clock_init; // Forward-clock reset, high = held
	logic frame_tick; // Framing clock enable pulse
	logic pll_locked_final; // Device reports final divisor lock
	logic cfg_loaded; // Device reports cache box config loaded
	logic selftest_result_pin; // Self-test result
	logic boot_rom_output_enable_n; // Boot rom enable, low while loading
	modport device (
		input power_good_in, reset_n, fwd_clock_init, frame_tick,
		output pll_locked_final, cfg_loaded, selftest_result_pin,
		output boot_rom_output_enable_n
	);
	modport host (
		output power_good_in, reset_n, fwd_clock_init, frame_tick,
		input pll_locked_final, cfg_loaded, selftest_result_pin,
		input boot_rom_output_enable_n
	);
endinterface : prs_link_if
`default_nettype wire

// ---- hw/prs_device.sv ----
// Purpose: device-side power-up reset state machine with PLL ramp
// Assumes: ref_clk stands for the core clock; frame_tick is the framing clock
// Notes: PLL itself is modelled by a divider select and a rate output
//
// Function
// - Power good low holds initial state, nominal
// - After power good, wait nominal at /16
// - Nominal core rate is reference times ratio/16
// - Board starts reference clocks before power good
// - Board holds reset 100 ms past power good
// - Reset release enters half rate, /2
// - Half rate counts 4108 cycles, then full
// - Full rate counts 8205 cycles for lock
// - Board releases init after lock, two frames
// - First release starts self-test one frame later
// - Self-test runs about 700000 cycles
// - Result pin low in reset, high testing
// - Result low 16 cycles, then pass/fail
// - Rom load only after pass; release enable
// - After rom, wait second init release
// - Board second release after config loaded
// - Second release resets link, starts clocks
// - Wait 264 cycles before system commands
// - Run fetches from address 0x780
// - Board accepts probes after link init
`include "prs_cfg.svh"
`default_nettype none
module prs_device #(
	parameter int HALF_CYCLES = `PRS_HALF_CYCLES,
	parameter int FULL_CYCLES = `PRS_FULL_CYCLES,
	parameter int SELFTEST_CYCLES = `PRS_SELFTEST_CYCLES,
	parameter int ROM_CYCLES = `PRS_ROM_CYCLES,
	parameter int CFG_CYCLES = `PRS_CFG_LOADED_CYCLES,
	parameter logic [3:0] CORE_RATIO = 4'h8,
	parameter logic SELFTEST_FAIL = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst,
	prs_link_if.device link,
	output logic [4:0] ref_divide,
	output logic [3:0] core_ratio,
	output logic fwd_link_reset,
	output logic fwd_clocks_run,
	output logic internal_reset,
	output logic cmd_enable,
	output logic fetch_valid,
	output logic [15:0] fetch_addr,
	output prs_pkg::prs_state_type state
);
	// ****************************************
	// Registers
	// ****************************************
	prs_pkg::prs_state_type state_q; // Reset state machine
	logic [19:0] dur_q; // Shared duration counter
	logic init_prev_q; // Last sampled forward-clock init
	logic [4:0] div_q; // Effective reference divide
	logic result_q; // Self-test result pin
	logic rom_oe_n_q; // Boot rom enable
	logic cfg_q; // Cache box config loaded
	logic lock_q; // Final lock reached
	logic link_rst_q; // Link reset pulse
	logic clk_run_q; // Outgoing clocks running
	logic int_rst_q; // Internal reset
	logic cmd_q; // Commands allowed
	logic fetch_q; // Fetch running
	logic init_fall; // Deasserting edge of init

	// Deasserting edge, sampled synchronously
	assign init_fall = init_prev_q && !link.fwd_clock_init;

	// ****************************************
	// Edge sampler
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			init_prev_q <= 1'b1;
		else
			init_prev_q <= link.fwd_clock_init;
	end

	// ****************************************
	// State machine and duration counter
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst || !link.power_good_in)
		begin
			state_q <= prs_pkg::state_init;
			dur_q <= 20'h0_0000;
		end
		else
		begin
			dur_q <= dur_q + 20'h0_0001;
			case (state_q)
				prs_pkg::state_init:
				begin
					// Power good seen: wait for reset release
					state_q <= prs_pkg::state_wait_nominal;
					dur_q <= 20'h0_0000;
				end
				prs_pkg::state_wait_nominal:
				begin
					// No lock gate: reset release alone moves on
					if (link.reset_n)
					begin
						state_q <= prs_pkg::state_half_rate;
						dur_q <= 20'h0_0000;
					end
				end
				prs_pkg::state_half_rate:
					if (dur_q == 20'(HALF_CYCLES - 1))
					begin
						state_q <= prs_pkg::state_full_rate;
						dur_q <= 20'h0_0000;
					end
				prs_pkg::state_full_rate:
					if (dur_q == 20'(FULL_CYCLES - 1))
					begin
						state_q <= prs_pkg::state_wait_release1;
						dur_q <= 20'h0_0000;
					end
				prs_pkg::state_wait_release1:
					// Armed on release; test starts on the next frame tick
					if (init_fall)
					begin
						state_q <= prs_pkg::state_self_test;
						dur_q <= 20'h0_0000;
					end
				prs_pkg::state_self_test:
				begin
					// Hold count at zero until the frame tick that starts the test
					if (dur_q == 20'h0_0000 && !link.frame_tick && !result_q)
						dur_q <= 20'h0_0000;
					else if (dur_q == 20'(SELFTEST_CYCLES))
					begin
						state_q <= prs_pkg::state_result_low;
						dur_q <= 20'h0_0000;
					end
				end
				prs_pkg::state_result_low:
					if (dur_q == 20'(`PRS_RESULT_LOW_CYCLES - 1))
					begin
						state_q <= SELFTEST_FAIL ? prs_pkg::state_failed
							: prs_pkg::state_rom_load;
						dur_q <= 20'h0_0000;
					end
				prs_pkg::state_rom_load:
					if (dur_q == 20'(ROM_CYCLES - 1))
					begin
						state_q <= prs_pkg::state_wait_link_init;
						dur_q <= 20'h0_0000;
					end
				prs_pkg::state_wait_link_init:
					if (init_fall)
					begin
						state_q <= prs_pkg::state_quiet;
						dur_q <= 20'h0_0000;
					end
				prs_pkg::state_quiet:
					if (dur_q == 20'(`PRS_QUIET_CYCLES - 1))
					begin
						state_q <= prs_pkg::state_run;
						dur_q <= 20'h0_0000;
					end
				prs_pkg::state_run, prs_pkg::state_failed:
					// Terminal; counter parked
					dur_q <= 20'h0_0000;
				default:
					state_q <= prs_pkg::state_init;
			endcase
		end
	end

	// ****************************************
	// PLL ramp divider select
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst || !link.power_good_in)
			div_q <= 5'(`PRS_NOMINAL_DIV);
		else if (state_q == prs_pkg::state_half_rate)
			div_q <= 5'(`PRS_HALF_DIV);
		else if (state_q == prs_pkg::state_full_rate || state_q > prs_pkg::state_full_rate)
			div_q <= 5'(`PRS_FULL_DIV);
		else
			div_q <= 5'(`PRS_NOMINAL_DIV);
	end

	// ****************************************
	// Result pin and boot rom enable
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst || !link.power_good_in)
			result_q <= 1'b0;
		else if (state_q == prs_pkg::state_self_test && link.frame_tick)
			result_q <= 1'b1;
		else if (state_q == prs_pkg::state_result_low || state_q == prs_pkg::state_rom_load)
			result_q <= 1'b0;
		else if (state_q == prs_pkg::state_failed)
			result_q <= 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || !link.power_good_in)
		begin
			rom_oe_n_q <= 1'b1;
			cfg_q <= 1'b0;
		end
		else
		begin
			// Enable low only while loading after a pass
			rom_oe_n_q <= !(state_q == prs_pkg::state_rom_load &&
				dur_q != 20'(ROM_CYCLES - 1));
			if (state_q == prs_pkg::state_rom_load && dur_q == 20'(CFG_CYCLES))
				cfg_q <= 1'b1;
		end
	end

	// ****************************************
	// Link init, internal reset and fetch
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst || !link.power_good_in)
		begin
			lock_q <= 1'b0;
			link_rst_q <= 1'b1;
			clk_run_q <= 1'b0;
			int_rst_q <= 1'b1;
			cmd_q <= 1'b0;
			fetch_q <= 1'b0;
		end
		else
		begin
			lock_q <= state_q >= prs_pkg::state_wait_release1;
			// One-cycle link reset pulse on the second release
			link_rst_q <= state_q == prs_pkg::state_wait_link_init && init_fall;
			if (state_q == prs_pkg::state_wait_link_init && init_fall)
			begin
				clk_run_q <= 1'b1;
				int_rst_q <= 1'b0;
			end
			cmd_q <= state_q == prs_pkg::state_run;
			fetch_q <= state_q == prs_pkg::state_run;
		end
	end

	assign link.pll_locked_final = lock_q;
	assign link.cfg_loaded = cfg_q;
	assign link.selftest_result_pin = result_q;
	assign link.boot_rom_output_enable_n = rom_oe_n_q;
	assign ref_divide = div_q;
	assign core_ratio = CORE_RATIO;
	assign fwd_link_reset = link_rst_q;
	assign fwd_clocks_run = clk_run_q;
	assign internal_reset = int_rst_q;
	assign cmd_enable = cmd_q;
	assign fetch_valid = fetch_q;
	assign fetch_addr = `PRS_FETCH_ADDR;
	assign state = state_q;
endmodule : prs_device
`default_nettype wire

// ---- hw/prs_host.sv ----
// Purpose: board controller driving power good, reset and forward-clock init
// Assumes: reference clock runs from reset onward
// Notes: framing clock is a divider enable pulse
`include "prs_cfg.svh"
`default_nettype none
module prs_host #(
	parameter int HOLD_CYCLES = `PRS_RESET_HOLD_CYCLES,
	parameter int FRAME_DIV = `PRS_FRAME_DIV
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic supply_ok,
	prs_link_if.host link,
	output logic probe_ready,
	output logic selftest_failed
);
	// ****************************************
	// Registers
	// ****************************************
	prs_pkg::prs_host_type st_q; // Board sequence
	logic [31:0] cnt_q; // Hold counter
	logic [7:0] fdiv_q; // Framing divider
	logic tick_q; // Framing enable pulse
	logic pg_q; // Power good
	logic rst_n_q; // System reset
	logic init_q; // Forward-clock init
	logic ready_q; // Probes accepted
	logic fail_q; // Result seen high after test
	logic pin_prev_q; // Result pin one cycle back
	logic pin_fell_q; // Result pin has dropped once

	// Framing clock divider
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			fdiv_q <= 8'h00;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= fdiv_q == 8'(FRAME_DIV - 1);
			fdiv_q <= (fdiv_q == 8'(FRAME_DIV - 1)) ? 8'h00 : fdiv_q + 8'h01;
		end
	end

	// Board sequence
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_q <= prs_pkg::host_power_off;
			cnt_q <= 32'h0000_0000;
			pg_q <= 1'b0;
			rst_n_q <= 1'b0;
			init_q <= 1'b1;
			ready_q <= 1'b0;
		end
		else
		begin
			case (st_q)
				prs_pkg::host_power_off:
					// Reference already runs; reset held low first
					if (supply_ok)
					begin
						pg_q <= 1'b1;
						cnt_q <= 32'h0000_0000;
						st_q <= prs_pkg::host_reset_hold;
					end
				prs_pkg::host_reset_hold:
				begin
					cnt_q <= cnt_q + 32'h0000_0001;
					if (cnt_q == 32'(HOLD_CYCLES - 1))
					begin
						rst_n_q <= 1'b1;
						st_q <= prs_pkg::host_wait_lock;
					end
				end
				prs_pkg::host_wait_lock:
					if (link.pll_locked_final && tick_q)
					begin
						init_q <= 1'b0;
						cnt_q <= 32'h0000_0000;
						st_q <= prs_pkg::host_release1;
					end
				prs_pkg::host_release1:
					if (tick_q)
					begin
						cnt_q <= cnt_q + 32'h0000_0001;
						if (cnt_q == 32'(`PRS_INIT_LOW_FRAMES - 1))
						begin
							init_q <= 1'b1;
							st_q <= prs_pkg::host_wait_config;
						end
					end
				prs_pkg::host_wait_config:
					if (link.cfg_loaded && link.boot_rom_output_enable_n && tick_q)
					begin
						init_q <= 1'b0;
						st_q <= prs_pkg::host_release2;
					end
				prs_pkg::host_release2:
				begin
					ready_q <= 1'b1;
					st_q <= prs_pkg::host_done;
				end
				prs_pkg::host_done:
					ready_q <= 1'b1;
				default:
					st_q <= prs_pkg::host_power_off;
			endcase
		end
	end

	// Failure is the pin rising again after the low window that ends the test;
	// the pin is also high while the test runs, so a plain level would misfire
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pin_prev_q <= 1'b0;
			pin_fell_q <= 1'b0;
			fail_q <= 1'b0;
		end
		else
		begin
			pin_prev_q <= link.selftest_result_pin;
			// Falling edge marks the end of the test
			if (pin_prev_q && !link.selftest_result_pin)
				pin_fell_q <= 1'b1;
			// High again after the drop means a failed test
			if (pin_fell_q && link.selftest_result_pin)
				fail_q <= 1'b1;
		end
	end

	assign link.power_good_in = pg_q;
	assign link.reset_n = rst_n_q;
	assign link.fwd_clock_init = init_q;
	assign link.frame_tick = tick_q;
	assign probe_ready = ready_q;
	assign selftest_failed = fail_q;
endmodule : prs_host
`default_nettype wire

// ---- bench/prs_link_props.sv ----
// Purpose: checker on the pins between sequencer and board controller
// Assumes: one clock, synchronous active-high reset
// Notes: counts come in as parameters so shortened runs still check the windows, with a few cycles of slack
`default_nettype none
module prs_link_props #(
	parameter int HOLD_CYCLES = 20,
	parameter int HALF_CYCLES = 10,
	parameter int FULL_CYCLES = 20,
	parameter int SELFTEST_CYCLES = 50
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic power_good_in,
	input wire logic reset_n,
	input wire logic fwd_clock_init,
	input wire logic frame_tick,
	input wire logic pll_locked_final,
	input wire logic cfg_loaded,
	input wire logic selftest_result_pin,
	input wire logic boot_rom_output_enable_n
);
	// ****************************************
	// Helper counters
	// ****************************************
	// Slack of a few cycles for registered state hand-offs
	localparam int LOCK_MIN = HALF_CYCLES + FULL_CYCLES - 1;
	localparam int LOCK_MAX = HALF_CYCLES + FULL_CYCLES + 4;
	int pg_cnt_q; // Cycles with supply good
	int lock_cnt_q; // Cycles since reset release
	int test_cnt_q; // Cycles with result pin high
	// Saturates so a long run cannot wrap
	always_ff @(posedge ref_clk)
		if (rst || !power_good_in) pg_cnt_q <= 0;
		else if (pg_cnt_q < HOLD_CYCLES) pg_cnt_q <= pg_cnt_q + 1;
	// Stops once lock is reported
	always_ff @(posedge ref_clk)
		if (rst || !reset_n) lock_cnt_q <= 0;
		else if (!pll_locked_final) lock_cnt_q <= lock_cnt_q + 1;
	// Restarts whenever the pin drops
	always_ff @(posedge ref_clk)
		if (rst || !selftest_result_pin) test_cnt_q <= 0;
		else test_cnt_q <= test_cnt_q + 1;
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_pg_low;
		!power_good_in |=> !selftest_result_pin && boot_rom_output_enable_n && !pll_locked_final;
	endproperty
	property p_reset_low;
		power_good_in && !reset_n |=> !selftest_result_pin && !pll_locked_final;
	endproperty
	property p_hold;
		$rose(reset_n) |-> power_good_in && pg_cnt_q >= HOLD_CYCLES;
	endproperty
	property p_lock_time;
		$rose(pll_locked_final) |-> lock_cnt_q >= LOCK_MIN && lock_cnt_q <= LOCK_MAX;
	endproperty
	property p_release1;
		$fell(fwd_clock_init) |-> pll_locked_final ##1 !fwd_clock_init [*7];
	endproperty
	property p_test_start;
		$fell(fwd_clock_init) && !cfg_loaded |-> ##[2:11] selftest_result_pin;
	endproperty
	property p_test_len;
		$fell(selftest_result_pin) && power_good_in |->
			test_cnt_q >= SELFTEST_CYCLES && test_cnt_q <= SELFTEST_CYCLES + 4;
	endproperty
	property p_result_low;
		$fell(selftest_result_pin) && power_good_in |->
			!selftest_result_pin [*8] ##1 !selftest_result_pin [*8];
	endproperty
	property p_rom_after_pass;
		$fell(boot_rom_output_enable_n) |-> !selftest_result_pin && !$past(selftest_result_pin, 8);
	endproperty
	property p_cfg_in_rom;
		$rose(cfg_loaded) |-> !boot_rom_output_enable_n;
	endproperty
	property p_release2;
		$fell(fwd_clock_init) && cfg_loaded |-> boot_rom_output_enable_n;
	endproperty
	a_pg_low: assert property (p_pg_low) else $error("state not cleared by supply low");
	a_reset_low: assert property (p_reset_low) else $error("result pin high in reset");
	a_hold: assert property (p_hold) else $error("reset released too early");
	a_lock_time: assert property (p_lock_time) else $error("lock interval wrong");
	a_release1: assert property (p_release1) else $error("init release bad");
	a_test_start: assert property (p_test_start) else $error("test start late");
	a_test_len: assert property (p_test_len) else $error("test length wrong");
	a_result_low: assert property (p_result_low) else $error("result low window short");
	a_rom_after_pass: assert property (p_rom_after_pass) else $error("rom load bad");
	a_cfg_in_rom: assert property (p_cfg_in_rom) else $error("config outside rom");
	a_release2: assert property (p_release2) else $error("second release early");
	// Main scenarios reached
	c_lock: cover property ($rose(pll_locked_final));
	c_rom: cover property ($fell(boot_rom_output_enable_n));
	c_link: cover property ($fell(fwd_clock_init) && cfg_loaded);
endmodule : prs_link_props
`default_nettype wire

// ---- bench/powerup_pll_ramp_sequencer_tb.sv ----
// Purpose: self-checking bench of device and board controller back to back
// Assumes: shortened counts; second device on a bench-driven link fails self-test
// Notes: inputs change on the falling edge
`include "prs_cfg.svh"
`default_nettype none
module powerup_pll_ramp_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Setup
	// ****************************************
	localparam int HALF = 10; // Shortened lock intervals
	localparam int FULL = 20;
	localparam int TEST = 50;
	localparam int HOLD = 20;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic supply_ok = 1'b0;
	int seed = 32'h3a31_3115;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	int half_n, full_n, quiet_n, low_n, pulse_n; // State durations and link reset pulse width seen
	logic prev_ok = 1'b0; // Divide check only across steady cycles
	logic [4:0] ref_divide;
	logic [3:0] core_ratio;
	logic fwd_link_reset, fwd_clocks_run, internal_reset, cmd_enable, fetch_valid;
	logic probe_ready, selftest_failed;
	logic [15:0] fetch_addr;
	prs_pkg::prs_state_type state, state_b, prev_state;
	prs_link_if link_a();
	prs_link_if link_b();
	always #5 ref_clk = ~ref_clk;
	prs_host #(.HOLD_CYCLES(HOLD), .FRAME_DIV(8)) u_prs_host (.ref_clk(ref_clk), .rst(rst),
		.supply_ok(supply_ok), .link(link_a), .probe_ready(probe_ready),
		.selftest_failed(selftest_failed));
	prs_device #(.HALF_CYCLES(HALF), .FULL_CYCLES(FULL), .SELFTEST_CYCLES(TEST),
		.ROM_CYCLES(100), .CFG_CYCLES(10)) u_prs_device (.ref_clk(ref_clk), .rst(rst),
		.link(link_a), .ref_divide(ref_divide), .core_ratio(core_ratio),
		.fwd_link_reset(fwd_link_reset), .fwd_clocks_run(fwd_clocks_run),
		.internal_reset(internal_reset), .cmd_enable(cmd_enable), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .state(state));
	// Failing part on a link the bench drives itself
	prs_device #(.HALF_CYCLES(HALF), .FULL_CYCLES(FULL), .SELFTEST_CYCLES(TEST),
		.SELFTEST_FAIL(1'b1)) u_prs_device_2 (.ref_clk(ref_clk), .rst(rst), .link(link_b),
		.ref_divide(), .core_ratio(), .fwd_link_reset(), .fwd_clocks_run(),
		.internal_reset(), .cmd_enable(), .fetch_valid(), .fetch_addr(), .state(state_b));
	prs_link_props #(.HOLD_CYCLES(HOLD), .HALF_CYCLES(HALF), .FULL_CYCLES(FULL),
		.SELFTEST_CYCLES(TEST)) u_prs_link_props (.ref_clk(ref_clk), .rst(rst),
		.power_good_in(link_a.power_good_in), .reset_n(link_a.reset_n),
		.fwd_clock_init(link_a.fwd_clock_init), .frame_tick(link_a.frame_tick),
		.pll_locked_final(link_a.pll_locked_final), .cfg_loaded(link_a.cfg_loaded),
		.selftest_result_pin(link_a.selftest_result_pin),
		.boot_rom_output_enable_n(link_a.boot_rom_output_enable_n));
	// ****************************************
	// Compare and closing tasks
	// ****************************************
	task automatic check_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check_vec
	task automatic check_state(input string what, input prs_pkg::prs_state_type exp,
		input prs_pkg::prs_state_type got);
		check_vec(what, {12'h000, exp}, {12'h000, got});
	endtask : check_state
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// Divide expected one cycle after the state
	function automatic logic [15:0] exp_div(input prs_pkg::prs_state_type s);
		if (s == prs_pkg::state_init || s == prs_pkg::state_wait_nominal) return 16'h0010;
		return (s == prs_pkg::state_half_rate) ? 16'h0002 : 16'h0001;
	endfunction : exp_div
	// Bench frame pulse on the second link
	always @(negedge ref_clk) link_b.frame_tick = (cycles % 8 == 0);
	// ****************************************
	// Monitor: divide, durations, timeout
	// ****************************************
	always @(negedge ref_clk)
	begin
		cycles++;
		if (prev_ok && !rst && link_a.power_good_in)
			check_vec("ref_divide", exp_div(prev_state), {11'h000, ref_divide});
		half_n += (state == prs_pkg::state_half_rate);
		full_n += (state == prs_pkg::state_full_rate);
		quiet_n += (state == prs_pkg::state_quiet);
		low_n += (state == prs_pkg::state_result_low);
		pulse_n += (fwd_link_reset && !internal_reset);
		prev_ok = !rst && link_a.power_good_in;
		prev_state = state;
		// Ceiling well above the three power-ups; last so nothing follows the end
		if (cycles == 6000)
		begin
			miscompares++;
			end_sim();
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		link_b.power_good_in = 1'b0;
		link_b.reset_n = 1'b0;
		link_b.fwd_clock_init = 1'b1;
		// Two passing power-ups, the second after a reset in mid-run
		repeat (2)
		begin
			rst = 1'b1;
			supply_ok = 1'b0;
			repeat (6) @(negedge ref_clk);
			rst = 1'b0;
			{half_n, full_n, quiet_n, low_n, pulse_n} = '0;
			repeat ($unsigned($random(seed)) % 16) @(negedge ref_clk);
			supply_ok = 1'b1;
			for (int i = 0; i < 2000 && fetch_valid !== 1'b1; i++) @(negedge ref_clk);
			check_vec("half_cycles", 16'(HALF), 16'(half_n));
			check_vec("full_cycles", 16'(FULL), 16'(full_n));
			check_vec("low_cycles", 16'd16, 16'(low_n));
			check_vec("quiet_cycles", 16'(`PRS_QUIET_CYCLES), 16'(quiet_n));
			check_vec("link_pulse", 16'd1, 16'(pulse_n));
			check_vec("run_flags", 16'h001f, {11'h000, cmd_enable, fwd_clocks_run, probe_ready,
				!internal_reset, link_a.boot_rom_output_enable_n});
			check_vec("fetch_addr", 16'h0780, fetch_addr);
			check_vec("core_ratio", 16'h0008, {12'h000, core_ratio});
			check_vec("selftest_failed", 16'h0000, {15'h0000, selftest_failed});
			check_state("state", prs_pkg::state_run, state);
			$display("Test power-up run done");
		end
		// Failing self-test; early release must be ignored in nominal
		link_b.power_good_in = 1'b1;
		repeat (3 + $unsigned($random(seed)) % 8) @(negedge ref_clk);
		link_b.fwd_clock_init = 1'b0;
		repeat (20) @(negedge ref_clk);
		check_state("early_release", prs_pkg::state_wait_nominal, state_b);
		link_b.fwd_clock_init = 1'b1;
		link_b.reset_n = 1'b1;
		for (int i = 0; i < 200 && link_b.pll_locked_final !== 1'b1; i++) @(negedge ref_clk);
		link_b.fwd_clock_init = 1'b0;
		repeat (16) @(negedge ref_clk);
		link_b.fwd_clock_init = 1'b1;
		for (int i = 0; i < 400 && state_b !== prs_pkg::state_failed; i++) @(negedge ref_clk);
		// Pin register lags the state by one cycle: last cycle of the low window
		check_vec("fail_low", 16'h0000, {15'h0000, link_b.selftest_result_pin});
		@(negedge ref_clk);
		check_vec("fail_pins", 16'h0003, {14'h0000, link_b.selftest_result_pin,
			link_b.boot_rom_output_enable_n & !link_b.cfg_loaded});
		link_b.power_good_in = 1'b0;
		repeat (2) @(negedge ref_clk);
		check_state("pg_low", prs_pkg::state_init, state_b);
		check_vec("pg_low_pin", 16'h0000, {15'h0000, link_b.selftest_result_pin});
		$display("Test self-test failure done");
		end_sim();
	end
endmodule : powerup_pll_ramp_sequencer_tb
`default_nettype wire
